// ==== src/sspsc_pkg.sv ====
// Purpose: Shared constants and types for the serial port status and control block.
// Assumes: Processor I/O space with a 16-bit address and 16-bit data.
// Notes: All offsets, field positions, reset values and counts live here.
package sspsc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] SSPSC_STATUS_CONTROL_ADDR = 16'hfff2;
  localparam logic [15:0] SSPSC_STATUS_CONTROL_RESET = 16'h0000;

  // ==========================================================================
  // Field positions
  localparam int SSPSC_BIT_PIN_LEVEL = 15;
  localparam int SSPSC_BIT_FS_INVERT = 14;
  localparam int SSPSC_BIT_FS_SOURCE = 13;
  localparam int SSPSC_BIT_ZERO_FLAG = 12;
  localparam int SSPSC_BIT_RESERVED = 11;
  localparam int SSPSC_BIT_CLK_INVERT = 10;
  localparam int SSPSC_BIT_CNT_CLK_SEL = 9;
  localparam int SSPSC_BIT_PRESCALE_EN = 8;
  localparam int SSPSC_TX_STAT_LSB = 5;
  localparam int SSPSC_RX_STAT_LSB = 2;
  localparam int SSPSC_BIT_SIGN_EXT = 1;
  localparam int SSPSC_BIT_WORD_SIZE = 0;

  // ==========================================================================
  // Data path sizes and counts
  localparam int SSPSC_WORD_W = 16;
  localparam int SSPSC_FIFO_DEPTH = 8;
  localparam int SSPSC_FIFO_CNT_W = 4;
  localparam logic [4:0] SSPSC_BITS_BYTE = 5'h08;
  localparam logic [4:0] SSPSC_BITS_WORD = 5'h10;
  localparam logic [3:0] SSPSC_FIFO_HALF = 4'h4;
  localparam logic [3:0] SSPSC_FIFO_FULL = 4'h8;

  // ==========================================================================
  // Five FIFO fill states
  localparam logic [2:0] SSPSC_FILL_EMPTY = 3'h0;
  localparam logic [2:0] SSPSC_FILL_LOW = 3'h1;
  localparam logic [2:0] SSPSC_FILL_HALF = 3'h2;
  localparam logic [2:0] SSPSC_FILL_HIGH = 3'h3;
  localparam logic [2:0] SSPSC_FILL_FULL = 3'h4;

  // ==========================================================================
  // Writable control settings, in register order
  typedef struct packed {
    logic frame_sync_invert;
    logic internal_frame_sync_source;
    logic shift_clock_invert;
    logic counter_clock_select;
    logic prescale_enable;
    logic sign_extend_enable;
    logic word_size_byte;
  } sspsc_ctrl_t;

  localparam sspsc_ctrl_t SSPSC_CTRL_RESET = '0;

  // I/O space access from the processor.
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } sspsc_io_t;

  // Frame sync generator states, Gray coded along idle, start, hold.
  typedef enum logic [1:0] {
    SSPSC_FS_IDLE = 2'b00,
    SSPSC_FS_START = 2'b01,
    SSPSC_FS_HOLD = 2'b11
  } sspsc_fs_state_t;

endpackage

// ==== src/sspsc_fifo.sv ====
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; push and pop may occur in the same cycle.
// Notes: The flush input empties the FIFO without touching stored words.
`timescale 1ns/100ps
`default_nettype none
module sspsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [CNT_W-1:0] o_count
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  // A full FIFO refuses input, so back-pressure reaches the source.
  assign o_in_ready = (count_reg != CNT_W'(DEPTH)) && !i_flush;
  assign o_out_valid = (count_reg != '0) && !i_flush;
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign o_count = count_reg;

  // ==========================================================================
  // Storage
  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  // ==========================================================================
  // Pointers and count
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end

endmodule
`default_nettype wire

// ==== src/sspsc_top.sv ====
// Purpose: Status and control register of the enhanced serial port, with the pin
//          polarity logic, shift clock prescaler, frame sync timing and FIFOs it steers.
// Assumes: i_clk_sys is the processor output clock; pins are asynchronous to it.
// Notes: The counter and frame sync prescaler live outside and report zero events.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Bit 15 reads back the live level of the serial receive pin.
// - Normal polarity: frame sync high one shift clock, transfer keyed on falling edge.
// - Inverted polarity: sync inverted and held for the whole 8 or 16 bit word.
// - Frame sync inversion applies once to outgoing and once to incoming sync.
// - Bit 13 picks frame sync from prescaler, or from transmit FIFO writes; writes pending together share one.
// - Bit 12 sets when frame sync prescaler hits zero; write 1 clears.
// - In counter mode the same bit sets when the 16-bit counter hits zero.
// - Setting that bit raises an interrupt only when the interrupt enable is set.
// - Bit 10 inverts the internal transmit shift clock and the receive shift clock.
// - Clock inversion applies once to transmit and once to receive shift clocks.
// - In counter mode bit 9 picks shift clock pin or processor clock for counter.
// - Outside counter mode the counter clock select has no effect.
// - Bit 8 lets the shift clock prescaler count; cleared, it stands still.
// - Bits 7-5 and 4-2 report transmit and receive FIFO fill in five states.
// - Byte mode: bit 1 picks sign or zero fill of the upper received byte.
// - Bit 0 resets to 16-bit words; set, it selects 8-bit words.
// - Port soft reset clears status bits and keeps control settings.
module sspsc_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire sspsc_pkg::sspsc_io_t i_io,
  output logic [15:0] o_io_rdata,
  input wire logic i_port_soft_reset,
  input wire logic i_general_counter_mode,
  input wire logic i_counter_interrupt_enable,
  input wire logic i_shift_clock_mode_select,
  input wire logic [7:0] i_shift_clock_divisor,
  input wire logic i_frame_sync_prescaler_zero,
  input wire logic i_counter_zero,
  output logic o_counter_interrupt,
  output logic o_counter_tick,
  input wire logic i_serial_receive_pin,
  input wire logic i_transmit_shift_clock,
  output logic o_transmit_shift_clock,
  output logic o_transmit_shift_clock_oe_n,
  input wire logic i_receive_shift_clock,
  output logic o_transmit_frame_sync,
  input wire logic i_receive_frame_sync,
  output logic o_core_receive_shift_clock,
  output logic o_core_receive_frame_sync,
  output logic o_shift_tick,
  input wire logic i_tx_valid,
  input wire logic [15:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_shift_tx_valid,
  output logic [15:0] o_shift_tx_data,
  input wire logic i_shift_tx_ready,
  input wire logic i_shift_rx_valid,
  input wire logic [15:0] i_shift_rx_data,
  output logic o_shift_rx_ready,
  output logic o_rx_valid,
  output logic [15:0] o_rx_data,
  input wire logic i_rx_ready
);
  import sspsc_pkg::*;

  // ==========================================================================
  // Fill state encoding, shared by both FIFO status fields
  function automatic logic [2:0] fill_state(input logic [3:0] cnt);
    if (cnt == 4'h0) begin
      return SSPSC_FILL_EMPTY;
    end else if (cnt < SSPSC_FIFO_HALF) begin
      return SSPSC_FILL_LOW;
    end else if (cnt == SSPSC_FIFO_HALF) begin
      return SSPSC_FILL_HALF;
    end else if (cnt < SSPSC_FIFO_FULL) begin
      return SSPSC_FILL_HIGH;
    end else begin
      return SSPSC_FILL_FULL;
    end
  endfunction

  // ==========================================================================
  // Pin synchronisers; only the second stage is read by any logic
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  wire [3:0] pin_raw = {i_serial_receive_pin, i_transmit_shift_clock,
                        i_receive_shift_clock, i_receive_frame_sync};
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire rx_pin_level = pin_sync_reg[3];
  wire ext_clk_level = pin_sync_reg[2];
  wire rx_clk_level = pin_sync_reg[1];
  wire rx_fs_level = pin_sync_reg[0];

  // ==========================================================================
  // Register decode
  sspsc_ctrl_t ctrl_reg;
  logic zero_flag_reg;
  wire hit = (i_io.addr == SSPSC_STATUS_CONTROL_ADDR);
  wire reg_wr = hit && i_io.wr;
  wire reg_rd = hit && i_io.rd;
  wire clear_flag = reg_wr && i_io.wdata[SSPSC_BIT_ZERO_FLAG];
  wire zero_event = i_frame_sync_prescaler_zero ||
                    (i_general_counter_mode && i_counter_zero);
  sspsc_ctrl_t ctrl_next;
  assign ctrl_next = '{
    frame_sync_invert: i_io.wdata[SSPSC_BIT_FS_INVERT],
    internal_frame_sync_source: i_io.wdata[SSPSC_BIT_FS_SOURCE],
    shift_clock_invert: i_io.wdata[SSPSC_BIT_CLK_INVERT],
    counter_clock_select: i_io.wdata[SSPSC_BIT_CNT_CLK_SEL],
    prescale_enable: i_io.wdata[SSPSC_BIT_PRESCALE_EN],
    sign_extend_enable: i_io.wdata[SSPSC_BIT_SIGN_EXT],
    word_size_byte: i_io.wdata[SSPSC_BIT_WORD_SIZE]
  };
  // The soft reset touches status only; control survives it.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= SSPSC_CTRL_RESET;
    end else if (reg_wr) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // The set term is tested first so it wins over a clearing write.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      zero_flag_reg <= 1'b0;
    end else if (zero_event) begin
      zero_flag_reg <= 1'b1;
    end else if (i_port_soft_reset || clear_flag) begin
      zero_flag_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Read data
  logic [3:0] tx_count;
  logic [3:0] rx_count;
  logic [15:0] rdata_next;
  assign rdata_next = {rx_pin_level, ctrl_reg.frame_sync_invert,
                       ctrl_reg.internal_frame_sync_source, zero_flag_reg,
                       1'b0, ctrl_reg.shift_clock_invert,
                       ctrl_reg.counter_clock_select, ctrl_reg.prescale_enable,
                       fill_state(tx_count), fill_state(rx_count),
                       ctrl_reg.sign_extend_enable, ctrl_reg.word_size_byte};
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_io_rdata <= SSPSC_STATUS_CONTROL_RESET;
    end else begin
      o_io_rdata <= reg_rd ? rdata_next : 16'h0000;
    end
  end

  // Interrupt on the rising edge of the flag, gated by the enable.
  logic flag_q_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flag_q_reg <= 1'b0;
      o_counter_interrupt <= 1'b0;
    end else begin
      flag_q_reg <= zero_flag_reg;
      o_counter_interrupt <= zero_flag_reg && !flag_q_reg && i_counter_interrupt_enable;
    end
  end

  // ==========================================================================
  // Shift clock prescaler; each half period lasts divisor plus one cycles
  logic [7:0] pre_cnt_reg;
  logic int_clk_reg;
  wire pre_wrap = (pre_cnt_reg == 8'h00);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_reg <= 8'h00;
      int_clk_reg <= 1'b0;
    end else if (ctrl_reg.prescale_enable) begin
      pre_cnt_reg <= pre_wrap ? i_shift_clock_divisor : pre_cnt_reg - 8'h01;
      int_clk_reg <= pre_wrap ? !int_clk_reg : int_clk_reg;
    end
  end

  // External clock edges are seen after synchronisation only.
  logic ext_clk_q_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ext_clk_q_reg <= 1'b0;
    end else begin
      ext_clk_q_reg <= ext_clk_level;
    end
  end
  wire int_tick = ctrl_reg.prescale_enable && pre_wrap && !int_clk_reg;
  wire ext_tick = ext_clk_level && !ext_clk_q_reg;
  wire pin_tick = i_shift_clock_mode_select ? int_tick : ext_tick;
  assign o_shift_tick = pin_tick;

  // Counter clock: shift clock pin edge or every processor clock.
  assign o_counter_tick = i_general_counter_mode &&
                          (ctrl_reg.counter_clock_select ? pin_tick : 1'b1);

  // ==========================================================================
  // Clock polarity, applied once in each direction
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_transmit_shift_clock <= 1'b0;
      o_core_receive_shift_clock <= 1'b0;
    end else begin
      o_transmit_shift_clock <= int_clk_reg ^ ctrl_reg.shift_clock_invert;
      o_core_receive_shift_clock <= rx_clk_level ^ ctrl_reg.shift_clock_invert;
    end
  end
  assign o_transmit_shift_clock_oe_n = !i_shift_clock_mode_select;

  // ==========================================================================
  // FIFOs
  wire tx_push = i_tx_valid && o_tx_ready;
  wire [15:0] rx_ext = ctrl_reg.word_size_byte ?
                       {ctrl_reg.sign_extend_enable ? {8{i_shift_rx_data[7]}} : 8'h00,
                        i_shift_rx_data[7:0]} : i_shift_rx_data;

  sspsc_fifo #(.WIDTH(SSPSC_WORD_W), .DEPTH(SSPSC_FIFO_DEPTH),
    .CNT_W(SSPSC_FIFO_CNT_W)) u_tx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_flush(i_port_soft_reset),
    .i_in_valid(i_tx_valid),
    .i_in_data(i_tx_data),
    .o_in_ready(o_tx_ready),
    .o_out_valid(o_shift_tx_valid),
    .o_out_data(o_shift_tx_data),
    .i_out_ready(i_shift_tx_ready),
    .o_count(tx_count)
  );

  sspsc_fifo #(.WIDTH(SSPSC_WORD_W), .DEPTH(SSPSC_FIFO_DEPTH),
    .CNT_W(SSPSC_FIFO_CNT_W)) u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_flush(i_port_soft_reset),
    .i_in_valid(i_shift_rx_valid),
    .i_in_data(rx_ext),
    .o_in_ready(o_shift_rx_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready),
    .o_count(rx_count)
  );

  // ==========================================================================
  // Frame sync generator
  sspsc_fs_state_t fs_state_reg;
  sspsc_fs_state_t fs_state_next;
  logic [4:0] fs_bits_reg;
  logic fs_pending_reg;
  wire fs_trigger = ctrl_reg.internal_frame_sync_source ?
                    i_frame_sync_prescaler_zero : tx_push;
  wire [4:0] word_bits = ctrl_reg.word_size_byte ? SSPSC_BITS_BYTE : SSPSC_BITS_WORD;
  // Inverted polarity holds the sync for the word; normal holds one shift clock.
  wire [4:0] fs_len = ctrl_reg.frame_sync_invert ? word_bits : 5'h01;
  wire fs_done = pin_tick && (fs_bits_reg == 5'h01);

  always_comb begin
    fs_state_next = fs_state_reg;
    case (fs_state_reg)
      SSPSC_FS_IDLE: begin
        if ((fs_trigger || fs_pending_reg) && pin_tick) begin
          fs_state_next = SSPSC_FS_START;
        end
      end
      SSPSC_FS_START: begin
        fs_state_next = fs_done ? SSPSC_FS_IDLE : SSPSC_FS_HOLD;
      end
      SSPSC_FS_HOLD: begin
        if (fs_done) begin
          fs_state_next = SSPSC_FS_IDLE;
        end
      end
      default: begin
        fs_state_next = SSPSC_FS_IDLE;
      end
    endcase
  end

  // A trigger arriving between shift clock edges waits for the next edge.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fs_state_reg <= SSPSC_FS_IDLE;
      fs_bits_reg <= 5'h00;
      fs_pending_reg <= 1'b0;
    end else if (i_port_soft_reset) begin
      fs_state_reg <= SSPSC_FS_IDLE;
      fs_bits_reg <= 5'h00;
      fs_pending_reg <= 1'b0;
    end else begin
      fs_state_reg <= fs_state_next;
      fs_pending_reg <= (fs_trigger || fs_pending_reg) &&
                        (fs_state_reg != SSPSC_FS_IDLE || !pin_tick);
      if (fs_state_reg == SSPSC_FS_IDLE) begin
        fs_bits_reg <= fs_len;
      end else if (pin_tick) begin
        fs_bits_reg <= fs_bits_reg - 5'h01;
      end
    end
  end

  wire fs_active = (fs_state_reg != SSPSC_FS_IDLE);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_transmit_frame_sync <= 1'b0;
      o_core_receive_frame_sync <= 1'b0;
    end else begin
      o_transmit_frame_sync <= fs_active ^ ctrl_reg.frame_sync_invert;
      o_core_receive_frame_sync <= rx_fs_level ^ ctrl_reg.frame_sync_invert;
    end
  end

  // ==========================================================================
  // Checks
  a_pin_level_read: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    reg_rd |=> o_io_rdata[15] == $past(pin_sync_reg[3]))
    else $error("receive pin level not reflected in bit 15");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_io_rdata[11] == 1'b0)
    else $error("reserved bit 11 read as one");
  a_flag_clear_one: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    clear_flag && !zero_event |=> !zero_flag_reg)
    else $error("write one did not clear zero flag");
  a_flag_write_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    reg_wr && !i_io.wdata[12] && !i_port_soft_reset |=>
      zero_flag_reg == $past(zero_flag_reg, 1) || $past(zero_event))
    else $error("write zero changed zero flag");
  a_set_beats_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_frame_sync_prescaler_zero || (i_general_counter_mode && i_counter_zero)) |=> zero_flag_reg)
    else $error("zero event lost");
  a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_counter_interrupt |-> $past(i_counter_interrupt_enable) && $past(zero_flag_reg) &&
      !$past(flag_q_reg))
    else $error("interrupt without enabled flag rise");
  a_prescaler_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !ctrl_reg.prescale_enable |=> $stable(pre_cnt_reg) && $stable(int_clk_reg))
    else $error("prescaler counted while disabled");
  a_counter_mode_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_general_counter_mode |-> !o_counter_tick)
    else $error("counter clocked outside counter mode");
  a_tx_fs_polarity: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_transmit_frame_sync == ($past(fs_active) ^ $past(ctrl_reg.frame_sync_invert)))
    else $error("transmit frame sync polarity wrong");
  a_clk_polarity: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_core_receive_shift_clock == ($past(rx_clk_level) ^ $past(ctrl_reg.shift_clock_invert)))
    else $error("receive shift clock polarity wrong");
  a_sign_fill: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ctrl_reg.word_size_byte |-> rx_ext[15:8] == (ctrl_reg.sign_extend_enable ?
                                {8{i_shift_rx_data[7]}} : 8'h00))
    else $error("upper byte fill wrong in byte mode");
  a_soft_reset_keep: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_port_soft_reset && !reg_wr |=> $stable(ctrl_reg) && (!zero_flag_reg || $past(zero_event)))
    else $error("soft reset disturbed control or kept status");

endmodule
`default_nettype wire

// ==== tb/sspsc_peer.sv ====
// Purpose: Far-side serial peripheral with looped shift clock and frame sync pins.
// Assumes: The peripheral never drives the shift clock while the port drives it.
// Notes: An undriven external shift clock stands still low between frames.
`timescale 1ns/100ps
`default_nettype none
module sspsc_peer (
  input wire logic i_pin_level,
  input wire logic i_tx_clk,
  input wire logic i_tx_clk_oe_n,
  input wire logic i_tx_fs,
  output logic o_rx_pin,
  output logic o_clk_wire,
  output logic o_rx_clk,
  output logic o_rx_fs
);
  // ==========================================================================
  // Pins
  // Looping transmit onto receive shows whether each direction is inverted once.
  assign o_clk_wire = i_tx_clk_oe_n ? 1'b0 : i_tx_clk;
  assign o_rx_clk = o_clk_wire;
  assign o_rx_fs = i_tx_fs;
  assign o_rx_pin = i_pin_level;
endmodule
`default_nettype wire

// ==== tb/serial_port_status_config_bench.sv ====
// Purpose: Self-checking bench for the serial port status and control block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Register rows run first, awkward cases follow.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module serial_port_status_config_bench;
  import sspsc_pkg::*;
  logic i_clk_sys, i_rst, i_port_soft_reset, i_general_counter_mode, i_counter_zero;
  logic i_counter_interrupt_enable, i_shift_clock_mode_select, i_frame_sync_prescaler_zero;
  logic i_tx_valid, i_shift_tx_ready, i_shift_rx_valid, i_rx_ready, pin, last;
  logic i_serial_receive_pin, i_transmit_shift_clock, i_receive_shift_clock;
  logic i_receive_frame_sync, o_counter_interrupt, o_counter_tick, o_transmit_shift_clock;
  logic o_transmit_shift_clock_oe_n, o_transmit_frame_sync, o_core_receive_shift_clock;
  logic o_core_receive_frame_sync, o_shift_tick, o_tx_ready, o_shift_tx_valid;
  logic o_shift_rx_ready, o_rx_valid;
  logic [7:0] i_shift_clock_divisor;
  logic [15:0] i_tx_data, i_shift_rx_data, o_io_rdata, o_shift_tx_data, o_rx_data, r;
  sspsc_io_t i_io;
  int n_fail = 0, comparisons = 0, k, t, hits;
  // Columns: write value, read back, received word in, received word out.
  logic [63:0] rows [5] = '{64'h0000_0000_1280_1280, 64'h0001_0001_1280_0080,
    64'h0003_0003_1280_ff80, 64'h0803_0003_127f_007f, 64'hffff_6703_1280_ff80};
  localparam logic [15:0] A = SSPSC_STATUS_CONTROL_ADDR;
  always #10 i_clk_sys = ~i_clk_sys;
  sspsc_top DUT (.i_clk_sys, .i_rst, .i_io, .o_io_rdata, .i_port_soft_reset,
    .i_general_counter_mode, .i_counter_interrupt_enable, .i_shift_clock_mode_select,
    .i_shift_clock_divisor, .i_frame_sync_prescaler_zero, .i_counter_zero,
    .o_counter_interrupt, .o_counter_tick, .i_serial_receive_pin, .i_transmit_shift_clock,
    .o_transmit_shift_clock, .o_transmit_shift_clock_oe_n, .i_receive_shift_clock,
    .o_transmit_frame_sync, .i_receive_frame_sync, .o_core_receive_shift_clock,
    .o_core_receive_frame_sync, .o_shift_tick, .i_tx_valid, .i_tx_data, .o_tx_ready,
    .o_shift_tx_valid, .o_shift_tx_data, .i_shift_tx_ready, .i_shift_rx_valid,
    .i_shift_rx_data, .o_shift_rx_ready, .o_rx_valid, .o_rx_data, .i_rx_ready);
  sspsc_peer peer (.i_pin_level(pin), .i_tx_clk(o_transmit_shift_clock),
    .i_tx_clk_oe_n(o_transmit_shift_clock_oe_n), .i_tx_fs(o_transmit_frame_sync),
    .o_rx_pin(i_serial_receive_pin), .o_clk_wire(i_transmit_shift_clock),
    .o_rx_clk(i_receive_shift_clock), .o_rx_fs(i_receive_frame_sync));
  // ==========================================================================
  // Tasks
  function automatic logic [2:0] fill(int n);
    return n == 0 ? SSPSC_FILL_EMPTY : n < 4 ? SSPSC_FILL_LOW : n == 4 ? SSPSC_FILL_HALF :
      n < 8 ? SSPSC_FILL_HIGH : SSPSC_FILL_FULL;
  endfunction
  task automatic wr(input logic [15:0] d);
    @(negedge i_clk_sys);
    i_io.addr = A;
    i_io.wdata = d;
    i_io.wr = 1'b1;
    @(negedge i_clk_sys);
    i_io.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge i_clk_sys);
    i_io.addr = a;
    i_io.rd = 1'b1;
    @(negedge i_clk_sys);
    i_io.rd = 1'b0;
    r = o_io_rdata;
  endtask
  // The interrupt pulse is counted over a short window so its exact cycle is not fixed.
  task automatic pulse(ref logic s);
    @(negedge i_clk_sys);
    s = 1'b1;
    @(negedge i_clk_sys);
    s = 1'b0;
    hits = 0;
    repeat (4) @(negedge i_clk_sys) if (o_counter_interrupt === 1'b1) hits++;
  endtask
  task automatic tog();
    t = 0;
    last = o_transmit_shift_clock;
    repeat (20) @(negedge i_clk_sys) begin
      if (o_transmit_shift_clock !== last) t++;
      last = o_transmit_shift_clock;
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    {i_clk_sys, i_port_soft_reset, i_general_counter_mode, i_counter_zero, pin} = '0;
    {i_counter_interrupt_enable, i_shift_clock_mode_select, i_frame_sync_prescaler_zero} = '0;
    {i_tx_valid, i_shift_tx_ready, i_shift_rx_valid, i_tx_data, i_shift_rx_data, i_io} = '0;
    i_rst = 1'b1;
    i_rx_ready = 1'b1;
    i_shift_clock_divisor = 8'h01;
    repeat (3) @(negedge i_clk_sys);
    i_rst = 1'b0;
    rd(A); `CHK("reset value", SSPSC_STATUS_CONTROL_RESET, r)
    rd(16'hfff3); `CHK("unmapped read", 16'h0000, r)
    for (k = 0; k < 5; k++) begin
      wr(rows[k][63:48]);
      rd(A); `CHK("register", rows[k][47:32], r)
      @(negedge i_clk_sys);
      i_shift_rx_valid = 1'b1;
      i_shift_rx_data = rows[k][31:16];
      @(negedge i_clk_sys);
      i_shift_rx_valid = 1'b0;
      `CHK("rx word", rows[k][15:0], o_rx_data)
      `CHK("rx valid", 1'b1, o_rx_valid)
    end
    repeat (4) @(negedge i_clk_sys);
    `CHK("fs idle inverted", 1'b1, o_transmit_frame_sync)
    `CHK("core fs", 1'b0, o_core_receive_frame_sync)
    `CHK("core clk", 1'b1, o_core_receive_shift_clock)
    pin = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    rd(A); `CHK("pin level", 1'b1, r[15])
    wr(16'h0000);
    i_shift_clock_mode_select = 1'b1;
    @(negedge i_clk_sys);
    tog(); `CHK("clock frozen", 0, t)
    `CHK("clock oe_n", 1'b0, o_transmit_shift_clock_oe_n)
    wr(16'h0100);
    tog(); `CHK("clock runs", 1'b1, t >= 9 && t <= 11)
    wr(16'h0000);
    i_shift_clock_mode_select = 1'b0;
    i_counter_interrupt_enable = 1'b1;
    pulse(i_frame_sync_prescaler_zero); `CHK("irq on", 1, hits)
    rd(A); `CHK("flag set", 1'b1, r[12])
    wr(16'h0000);
    rd(A); `CHK("flag kept", 1'b1, r[12])
    wr(16'h1000);
    rd(A); `CHK("flag cleared", 1'b0, r[12])
    i_counter_interrupt_enable = 1'b0;
    i_general_counter_mode = 1'b1;
    #1;
    `CHK("counter tick", 1'b1, o_counter_tick)
    pulse(i_counter_zero); `CHK("irq masked", 0, hits)
    rd(A); `CHK("counter flag", 1'b1, r[12])
    wr(16'h1000);
    @(negedge i_clk_sys);
    i_io.wr = 1'b1;
    i_frame_sync_prescaler_zero = 1'b1;
    @(negedge i_clk_sys);
    i_io.wr = 1'b0;
    i_frame_sync_prescaler_zero = 1'b0;
    rd(A); `CHK("set wins", 1'b1, r[12])
    wr(16'h0003);
    pulse(i_port_soft_reset);
    rd(A); `CHK("soft reset", 16'h8003, r)
    i_general_counter_mode = 1'b0;
    for (k = 1; k <= 9; k++) begin
      @(negedge i_clk_sys);
      i_tx_valid = 1'b1;
      i_tx_data = 16'(16'ha000 + k);
      @(negedge i_clk_sys);
      i_tx_valid = 1'b0;
      rd(A); `CHK("tx fill", fill(k > 8 ? 8 : k), r[7:5])
    end
    `CHK("tx full", 1'b0, o_tx_ready)
    for (k = 1; k <= 8; k++) begin
      `CHK("tx data", 16'(16'ha000 + k), o_shift_tx_data)
      i_shift_tx_ready = 1'b1;
      @(negedge i_clk_sys);
    end
    `CHK("tx empty", 1'b0, o_shift_tx_valid)
    i_shift_clock_mode_select = 1'b1;
    wr(16'h0100);
    hits = 0;
    repeat (20) @(negedge i_clk_sys) if (o_transmit_frame_sync === 1'b1) hits++;
    `CHK("fs width", 4, hits)
    stop_test();
  end
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
